/* File: timing_ring_pkg.sv */
/*
  Shared constants for the processor timing ring counter.
  Assumes one system clock; the selected source clock arrives as a synchronous level.
*/
package timing_ring_pkg;
  // System clock period
  localparam int CLOCK_PERIOD_NS = 8;
  // Number of timing pulses produced by the ring
  localparam int RING_STATES = 5;
  // Bit positions of the timing pulses on the output vectors
  localparam int PULSE_ONE = 0;
  localparam int PULSE_TWO = 1;
  localparam int PULSE_THREE = 2;
  localparam int PULSE_FOUR = 3;
  localparam int PULSE_FIVE = 4;
  // Reset values of ring flops, of the state-four clearing flop and of the phase edge flop
  localparam logic RING_RESET = 1'h0;
  localparam logic FOUR_CLEAR_RESET = 1'h1;
  localparam logic PHASE_RESET = 1'h0;
endpackage : timing_ring_pkg

/* File: phase_splitter.sv */
/*
  Phase splitter and buffers: complementary phase clocks, buffered time pulse
  and free-running clock pulse pairs, plus a one-cycle tick at the trailing
  edge of the buffered time pulse.
  Assumes selectedSourceClock is synchronous to clock and is active low.
*/
`timescale 1ns/1ps
module phase_splitter (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic selectedSourceClock,
  output logic phaseClockHigh,
  output logic phaseClockLow,
  output logic bufferedTimePulse,
  output logic bufferedTimePulseN,
  output logic freeRunningClockPulse,
  output logic freeRunningClockPulseN,
  output logic pulseTick
);
  typedef struct packed {
    logic highPrev;
  } split_state_t;

  split_state_t state;
  split_state_t next_state;

  // Phase clocks follow the source, high one inverted
  assign phaseClockHigh = ~selectedSourceClock; // R1
  assign phaseClockLow = selectedSourceClock; // R1
  // True copies in phase with the high phase clock
  assign bufferedTimePulse = phaseClockHigh; // R2
  assign bufferedTimePulseN = phaseClockLow; // R2
  assign freeRunningClockPulse = phaseClockHigh; // R2
  assign freeRunningClockPulseN = phaseClockLow; // R2
  // Both trailing edges coincide, so one tick serves all flops
  assign pulseTick = state.highPrev & ~phaseClockHigh; // R6

  // Remember last high phase level
  always_comb begin
    next_state = state;
    next_state.highPrev = phaseClockHigh;
  end

  // Register the state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= '{highPrev: timing_ring_pkg::PHASE_RESET};
    end else begin
      state <= next_state;
    end
  end

  // Phase clocks always opposite
  chk_phase_pair: assert property ( // R1
    @(posedge clock) disable iff (!rst_n)
    phaseClockHigh != phaseClockLow)
    else $error("phase clocks not complementary");
  // Tick only where the high phase has just ended
  chk_tick_edge: assert property ( // R6
    @(posedge clock) disable iff (!rst_n)
    pulseTick |-> $past(bufferedTimePulse) && !bufferedTimePulse)
    else $error("tick without trailing edge");
endmodule : phase_splitter

/* File: pulse_gate.sv */
/*
  Timing pulse gates: each timing pulse is one phase clock gated by one bit of the gate vector.
  Assumes the gate vector changes only at trailing edges of the phase clocks.
*/
`timescale 1ns/1ps
module pulse_gate #(
  parameter int WIDTH = timing_ring_pkg::RING_STATES
) (
  input wire logic phaseClockHigh,
  input wire logic phaseClockLow,
  input wire logic [WIDTH-1:0] gate,
  output logic [WIDTH-1:0] timingPulseHigh,
  output logic [WIDTH-1:0] timingPulseLowN
);
  // High pulses go high with the high phase; low pulses go low with the low phase
  assign timingPulseHigh = gate & {WIDTH{phaseClockHigh}}; // R12
  assign timingPulseLowN = ~gate | {WIDTH{phaseClockLow}}; // R12
endmodule : pulse_gate

/* File: cpu_timing_ring_counter.sv */
/*
  Processor timing generator core: phase split, buffered pulses, five-state
  ring counter with pulse helpers, and gated timing pulses.
  Assumes init, the stop-before-state-one request and the state-two hold are
  synchronous levels from the pause logic, stable before each tick.
*/
`timescale 1ns/1ps
// Behaviour
// R1 - High phase clock inverts source clock; low phase clock follows it.
// R2 - Buffered and free-running pulses come as true/complement pairs, true with high.
// R3 - Init clears the whole ring counter.
// R4 - State four cleared via flop set by init, released on next tick.
// R5 - With five, two, one-helper idle, next tick sets state four.
// R6 - All ring flops change together at the buffered pulse trailing edge; init and the four clearing flop act at any clock.
// R7 - After state four, next tick sets five and clears four.
// R8 - From five, tick sets one unless stop-before-one requested; then five holds.
// R9 - Tick after one sets two, never three at the same time.
// R10 - Next tick moves two to three, then three to four.
// R11 - Two and five pulse helpers last one tick; pulses emitted once.
// R12 - Timing pulses are phase clocks gated by ring states.
// R13 - Ring holds in two for bus transfers, in five for cache.
// R14 - Pause logic supplies hold requests synchronously before each tick.
module cpu_timing_ring_counter (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic selectedSourceClock,
  input wire logic initPulse,
  input wire logic holdBeforeStateOne,
  input wire logic holdInStateTwo,
  output logic phaseClockHigh,
  output logic phaseClockLow,
  output logic bufferedTimePulse,
  output logic bufferedTimePulseN,
  output logic freeRunningClockPulse,
  output logic freeRunningClockPulseN,
  output logic [timing_ring_pkg::RING_STATES-1:0] timingPulseHigh,
  output logic [timing_ring_pkg::RING_STATES-1:0] timingPulseLowN,
  output logic [timing_ring_pkg::RING_STATES-1:0] ringState
);
  typedef struct packed {
    logic stateOne;
    logic stateOneHelper;
    logic stateTwo;
    logic stateTwoPulseHelper;
    logic stateThree;
    logic stateFour;
    logic stateFive;
    logic stateFivePulseHelper;
    logic fourClear;
  } ring_state_t;

  ring_state_t state;
  ring_state_t next_state;
  logic pulseTick;
  logic armFour;
  logic advanceFive;
  logic advanceTwo;
  logic [timing_ring_pkg::RING_STATES-1:0] pulseEnable;

  // Clock phases and buffered pulse pairs
  phase_splitter splitter (
    .clock(clock),
    .rst_n(rst_n),
    .selectedSourceClock(selectedSourceClock),
    .phaseClockHigh(phaseClockHigh),
    .phaseClockLow(phaseClockLow),
    .bufferedTimePulse(bufferedTimePulse),
    .bufferedTimePulseN(bufferedTimePulseN),
    .freeRunningClockPulse(freeRunningClockPulse),
    .freeRunningClockPulseN(freeRunningClockPulseN),
    .pulseTick(pulseTick)
  );

  // Ring step conditions
  assign armFour = ~state.stateFive & ~state.stateTwo & ~state.stateOneHelper; // R5
  assign advanceFive = state.stateFive & ~holdBeforeStateOne; // R8 R13 R14
  assign advanceTwo = state.stateTwo & ~holdInStateTwo; // R13 R14

  // Next ring values: init applies at any clock, stepping only at the tick
  always_comb begin
    next_state = state;
    if (initPulse) begin
      next_state.stateOne = timing_ring_pkg::RING_RESET; // R3
      next_state.stateOneHelper = timing_ring_pkg::RING_RESET; // R3
      next_state.stateTwo = timing_ring_pkg::RING_RESET; // R3
      next_state.stateTwoPulseHelper = timing_ring_pkg::RING_RESET; // R3
      next_state.stateThree = timing_ring_pkg::RING_RESET; // R3
      next_state.stateFive = timing_ring_pkg::RING_RESET; // R3
      next_state.stateFivePulseHelper = timing_ring_pkg::RING_RESET; // R3
      next_state.fourClear = timing_ring_pkg::FOUR_CLEAR_RESET; // R4
    end else if (pulseTick) begin
      next_state.fourClear = 1'h0; // R4
      // Four: J from arm, goes off at the next tick whenever set
      next_state.stateFour = armFour & ~state.stateFour & ~state.fourClear; // R5 R7 R10
      // Five set from four, held while stopped
      next_state.stateFive = state.stateFour | (state.stateFive & ~advanceFive); // R7 R8
      next_state.stateFivePulseHelper = state.stateFour; // R11
      // One and its helper load together from the five exit
      next_state.stateOne = advanceFive; // R8
      next_state.stateOneHelper = advanceFive; // R9
      // Two set from one, held during pause
      next_state.stateTwo = state.stateOne | (state.stateTwo & ~advanceTwo); // R9 R13
      next_state.stateTwoPulseHelper = state.stateOne; // R11
      // Three needs two already active
      next_state.stateThree = advanceTwo; // R9 R10
    end
    // Four is held clear by its clearing flop, not by init directly
    if (state.fourClear) begin
      next_state.stateFour = 1'h0; // R4
    end
  end

  // Register the ring
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= '{stateOne: timing_ring_pkg::RING_RESET,
                 stateOneHelper: timing_ring_pkg::RING_RESET,
                 stateTwo: timing_ring_pkg::RING_RESET,
                 stateTwoPulseHelper: timing_ring_pkg::RING_RESET,
                 stateThree: timing_ring_pkg::RING_RESET,
                 stateFour: timing_ring_pkg::RING_RESET,
                 stateFive: timing_ring_pkg::RING_RESET,
                 stateFivePulseHelper: timing_ring_pkg::RING_RESET,
                 fourClear: timing_ring_pkg::FOUR_CLEAR_RESET};
    end else begin
      state <= next_state; // R6
    end
  end

  // Order five ring bits onto the pulse vector
  function automatic logic [timing_ring_pkg::RING_STATES-1:0] pack_ring(
    input logic one,
    input logic two,
    input logic three,
    input logic four,
    input logic five
  );
    logic [timing_ring_pkg::RING_STATES-1:0] ordered;
    ordered = '0;
    ordered[timing_ring_pkg::PULSE_ONE] = one;
    ordered[timing_ring_pkg::PULSE_TWO] = two;
    ordered[timing_ring_pkg::PULSE_THREE] = three;
    ordered[timing_ring_pkg::PULSE_FOUR] = four;
    ordered[timing_ring_pkg::PULSE_FIVE] = five;
    return ordered;
  endfunction : pack_ring

  // Helpers, not main flops, drive pulses two and five so a pause gives one pulse
  assign pulseEnable = pack_ring(state.stateOne, state.stateTwoPulseHelper, state.stateThree, state.stateFour,
    state.stateFivePulseHelper); // R11

  // Main ring flops for observers
  assign ringState = pack_ring(state.stateOne, state.stateTwo, state.stateThree, state.stateFour, state.stateFive);

  // Gate phase clocks with ring states
  pulse_gate #(.WIDTH(timing_ring_pkg::RING_STATES)) gates (
    .phaseClockHigh(phaseClockHigh),
    .phaseClockLow(phaseClockLow),
    .gate(pulseEnable),
    .timingPulseHigh(timingPulseHigh),
    .timingPulseLowN(timingPulseLowN)
  );

  // Init clears every ring flop but four and sets the clearing flop
  chk_init_clears: assert property ( // R3
    @(posedge clock) disable iff (!rst_n)
    initPulse |=> !state.stateOne && !state.stateTwo && !state.stateThree && !state.stateFive && state.fourClear)
    else $error("init left ring set");

  // Four is gone two edges after init, through the clearing flop
  chk_init_four_clear: assert property ( // R4
    @(posedge clock) disable iff (!rst_n)
    initPulse |-> ##2 !state.stateFour)
    else $error("four survived init");

  // Clearing flop keeps four off
  chk_four_held: assert property ( // R4
    @(posedge clock) disable iff (!rst_n)
    state.fourClear |=> !state.stateFour)
    else $error("four set while clearing flop on");

  // Clearing flop lets go only at a tick
  chk_clear_hold: assert property ( // R4
    @(posedge clock) disable iff (!rst_n)
    state.fourClear && !initPulse && !pulseTick |=> state.fourClear)
    else $error("clearing flop dropped off tick");

  // First tick after init drops the clearing flop
  chk_clear_release: assert property ( // R4
    @(posedge clock) disable iff (!rst_n)
    state.fourClear && !initPulse && pulseTick |=> !state.fourClear)
    else $error("clearing flop stuck");

  // Cleared ring starts by setting four
  chk_start_four: assert property ( // R5
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && !state.fourClear && ringState == 5'h00 && !state.stateOneHelper |=> state.stateFour)
    else $error("ring failed to start");

  // Four is not armed while five, two or the one helper is on
  chk_no_arm_busy: assert property ( // R5
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && (state.stateFive || state.stateTwo || state.stateOneHelper) |=> !state.stateFour)
    else $error("four set while ring busy");

  // Ring moves only at a tick
  chk_quiet_between: assert property ( // R6
    @(posedge clock) disable iff (!rst_n)
    !pulseTick && !initPulse && !state.fourClear |=> $stable(ringState))
    else $error("ring moved off tick");

  // All flops change together, so never two states at once
  chk_ring_onehot: assert property ( // R6
    @(posedge clock) disable iff (!rst_n)
    $onehot0(ringState))
    else $error("more than one ring flop set");

  // Four passes to five
  chk_four_to_five: assert property ( // R7
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && state.stateFour |=> state.stateFive && !state.stateFour)
    else $error("four did not pass");

  // Five leaves for one unless the stop request stands
  chk_five_exit: assert property ( // R8 R13
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && state.stateFive |=> (state.stateOne == !$past(holdBeforeStateOne)) &&
      (state.stateFive == $past(holdBeforeStateOne)))
    else $error("five exit wrong");

  // One comes only from five
  chk_one_from_five: assert property ( // R8
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && !state.stateFive |=> !state.stateOne)
    else $error("one set without five");

  // One passes to two, three stays off
  chk_one_to_two: assert property ( // R9
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && state.stateOne |=> state.stateTwo && !state.stateThree && !state.stateOne)
    else $error("one did not pass to two");

  // Two leaves for three unless held
  chk_two_exit: assert property ( // R10 R13
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && state.stateTwo && !state.stateOne |=> state.stateThree == !$past(holdInStateTwo))
    else $error("two exit wrong");

  // Three comes only from two
  chk_three_from_two: assert property ( // R10
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && !state.stateTwo |=> !state.stateThree)
    else $error("three set without two");

  // Three closes the loop into four
  chk_three_to_four: assert property ( // R10
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && state.stateThree |=> state.stateFour && !state.stateThree)
    else $error("loop not closed");

  // Two helper lasts one tick
  chk_helper_once: assert property ( // R11
    @(posedge clock) disable iff (!rst_n)
    pulseTick && state.stateTwoPulseHelper |=> !state.stateTwoPulseHelper)
    else $error("two helper held");

  // Five helper lasts one tick
  chk_five_helper_once: assert property ( // R11
    @(posedge clock) disable iff (!rst_n)
    pulseTick && state.stateFivePulseHelper |=> !state.stateFivePulseHelper)
    else $error("five helper held");

  // Two helper sets with two
  chk_two_helper_set: assert property ( // R11
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && state.stateOne |=> state.stateTwoPulseHelper)
    else $error("two helper missed");

  // Five helper sets with five
  chk_five_helper_set: assert property ( // R11
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && state.stateFour |=> state.stateFivePulseHelper)
    else $error("five helper missed");

  // Stop request keeps five, with no second pulse
  chk_hold_five: assert property ( // R13
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && state.stateFive && holdBeforeStateOne |=>
      state.stateFive && !state.stateFivePulseHelper)
    else $error("five not held");

  // Pause hold keeps two, with no second pulse
  chk_hold_two: assert property ( // R13
    @(posedge clock) disable iff (!rst_n)
    pulseTick && !initPulse && state.stateTwo && holdInStateTwo |=> state.stateTwo && !state.stateTwoPulseHelper)
    else $error("two not held");

  // High pulse five is the high phase gated by its helper
  chk_gate_pulse: assert property ( // R12
    @(posedge clock) disable iff (!rst_n)
    timingPulseHigh[timing_ring_pkg::PULSE_FIVE] |-> phaseClockHigh && state.stateFivePulseHelper)
    else $error("five pulse not gated");

  // Low pulse two is the low phase gated by its helper
  chk_low_pulse_gate: assert property ( // R12
    @(posedge clock) disable iff (!rst_n)
    !timingPulseLowN[timing_ring_pkg::PULSE_TWO] |-> !phaseClockLow && state.stateTwoPulseHelper)
    else $error("two low pulse not gated");

  // No high pulse outside the high phase
  chk_pulse_high_idle: assert property ( // R12
    @(posedge clock) disable iff (!rst_n)
    !phaseClockHigh |-> timingPulseHigh == '0)
    else $error("high pulse outside phase");

  // No low pulse outside the low phase
  chk_pulse_low_idle: assert property ( // R12
    @(posedge clock) disable iff (!rst_n)
    phaseClockLow |-> timingPulseLowN == '1)
    else $error("low pulse outside phase");
endmodule : cpu_timing_ring_counter

/* File: pause_logic_model.sv */
/*
  Pause logic model: makes the selected source clock and the two hold requests.
  Assumes the bench asks for holds as plain levels at any time.
*/
`timescale 1ns/1ps
module pause_logic_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic stopReq,
  input wire logic holdReq,
  output logic selectedSourceClock,
  output logic holdBeforeStateOne,
  output logic holdInStateTwo
);
  logic [1:0] cnt;
  logic idle;
  logic stopNow;
  logic holdNow;
  initial begin
    cnt = 2'h0;
    selectedSourceClock = 1'h1;
    holdBeforeStateOne = 1'h0;
    holdInStateTwo = 1'h0;
  end
  // Source low two cycles, high two; idle high
  always @(posedge clock) begin
    // Take bench levels at the edge, before the bench moves them
    idle = !rst_n || !run;
    stopNow = stopReq;
    holdNow = holdReq;
    #1;
    if (idle) cnt = 2'h0;
    else cnt = cnt + 2'h1;
    selectedSourceClock = idle || cnt[1];
    // Holds change only while source is low
    if (!selectedSourceClock) begin
      holdBeforeStateOne = stopNow;
      holdInStateTwo = holdNow;
    end
  end
endmodule : pause_logic_model

/* File: tb.sv */
/*
  Self-checking bench for the timing ring counter.
  Assumes the pause logic model drives source clock and holds.
*/
`timescale 1ns/1ps
module tb;
  logic clock, rst_n, run, stopReq, holdReq, initPulse;
  logic selectedSourceClock, holdBeforeStateOne, holdInStateTwo;
  logic phaseClockHigh, phaseClockLow, bufferedTimePulse, bufferedTimePulseN;
  logic freeRunningClockPulse, freeRunningClockPulseN;
  logic [4:0] timingPulseHigh, timingPulseLowN, ringState;
  int bad_count = 0;
  int samples_checked = 0;

  pause_logic_model pm_u (.clock, .rst_n, .run, .stopReq, .holdReq,
    .selectedSourceClock, .holdBeforeStateOne, .holdInStateTwo);
  cpu_timing_ring_counter dut_u (.clock, .rst_n, .selectedSourceClock, .initPulse,
    .holdBeforeStateOne, .holdInStateTwo, .phaseClockHigh, .phaseClockLow,
    .bufferedTimePulse, .bufferedTimePulseN, .freeRunningClockPulse,
    .freeRunningClockPulseN, .timingPulseHigh, .timingPulseLowN, .ringState);

  // Clock
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // Compare and count
  task check(input logic [4:0] seen, input logic [4:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task complete_run;
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // Stop in the cycle where the source rises
  task wait_tick;
    int n;
    n = 0;
    while (selectedSourceClock !== 1'h0 && n < 8) begin
      @(posedge clock);
      #2 n++;
    end
    while (selectedSourceClock !== 1'h1 && n < 16) begin
      @(posedge clock);
      #2 n++;
    end
    if (n >= 16) bad_count++;
  endtask : wait_tick

  // One tick: state, then pulses in both source halves
  task step(input logic [4:0] st, input logic [4:0] pu);
    wait_tick();
    @(posedge clock);
    #2 check(ringState, st);
    check(timingPulseHigh, 5'h00);
    check(timingPulseLowN, 5'h1f);
    check({3'h0, phaseClockHigh, phaseClockLow}, 5'h01);
    check({1'h0, bufferedTimePulse, bufferedTimePulseN, freeRunningClockPulse, freeRunningClockPulseN}, 5'h05);
    @(posedge clock);
    #2 check(timingPulseHigh, pu);
    check(timingPulseLowN, ~pu);
    check({3'h0, phaseClockHigh, phaseClockLow}, 5'h02);
    check({1'h0, bufferedTimePulse, bufferedTimePulseN, freeRunningClockPulse, freeRunningClockPulseN}, 5'h0a);
  endtask : step

  // Start-up and one full loop
  task t_start;
    step(5'h00, 5'h00);
    step(5'h08, 5'h08);
    step(5'h10, 5'h10);
    step(5'h01, 5'h01);
    step(5'h02, 5'h02);
    step(5'h04, 5'h04);
    step(5'h08, 5'h08);
  endtask : t_start

  // Stop before state one keeps five, one pulse only
  task t_stop_one;
    stopReq = 1'h1;
    step(5'h10, 5'h10);
    step(5'h10, 5'h00);
    step(5'h10, 5'h00);
    stopReq = 1'h0;
    step(5'h01, 5'h01);
  endtask : t_stop_one

  // Hold in state two, one pulse only
  task t_hold_two;
    holdReq = 1'h1;
    step(5'h02, 5'h02);
    step(5'h02, 5'h00);
    step(5'h02, 5'h00);
    holdReq = 1'h0;
    step(5'h04, 5'h04);
  endtask : t_hold_two

  // Init in state three clears and restarts
  task t_init;
    @(posedge clock);
    #1 initPulse = 1'h1;
    repeat (4) @(posedge clock);
    #1 initPulse = 1'h0;
    #1 check(ringState, 5'h00);
    step(5'h00, 5'h00);
    step(5'h08, 5'h08);
  endtask : t_init

  // Main sequence
  initial begin
    rst_n = 1'h0;
    run = 1'h0;
    stopReq = 1'h0;
    holdReq = 1'h0;
    initPulse = 1'h0;
    repeat (3) @(posedge clock);
    #1 rst_n = 1'h1;
    run = 1'h1;
    #1 t_start();
    t_stop_one();
    t_hold_two();
    t_init();
    complete_run();
  end

  // Watchdog
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
endmodule : tb
